// >>> hdl/mmrw_consts.svh
/*
 * Widths, sizes, reset values and fixed codes of the read/write endpoint.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef MMRW_CONSTS_SVH
`define MMRW_CONSTS_SVH

// Data path: read word and write word share this width
`define MMRW_DATA_W 32
// Word address: one bit above the memory index marks unmapped space
`define MMRW_ADDR_W 9
`define MMRW_IDX_W 8
`define MMRW_DEPTH 256
`define MMRW_MAP_BIT 8
// Burst length field; zero is taken as one beat
`define MMRW_BURST_W 4
`define MMRW_NO_BEAT 4'h0
`define MMRW_ONE_BEAT 4'h1
`define MMRW_ONE_ADDR 9'h001
// Strobe polarity: 1'b1 selects the active-low strobe variant
`define MMRW_STROBE_LOW 1'b0
// Reset values
`define MMRW_WAIT_RST 1'b1
`define MMRW_ADDR_RST 9'h000
`define MMRW_DATA_RST 32'h0000_0000
`define MMRW_WORDS_RST 256'h0
// Read word placed beside any fault status
`define MMRW_FAULT_DATA 32'h0000_0000
// Width of the status code
`define MMRW_STAT_W 2

`endif

// >>> hdl/mmrw_mem.sv
/*
 * On-chip word memory with one written-flag per word.
 * Assumes read and write never target it in the same cycle.
 */
`timescale 1ns/100ps
`include "mmrw_consts.svh"

module mmrw_mem (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Read port, one cycle latency
	input wire logic rd_en,
	input wire logic [`MMRW_IDX_W-1:0] rd_idx,
	output logic [`MMRW_DATA_W-1:0] rd_q,
	output logic rd_written,
	// Write port
	input wire logic wr_en,
	input wire logic [`MMRW_IDX_W-1:0] wr_idx,
	input wire logic [`MMRW_DATA_W-1:0] wr_data
);

	// Storage; contents are not cleared, only the flags are
	logic [`MMRW_DATA_W-1:0] word_mem [`MMRW_DEPTH];
	logic [`MMRW_DEPTH-1:0] written_reg;
	logic [`MMRW_DEPTH-1:0] written_next;
	logic [`MMRW_DATA_W-1:0] q_reg;
	logic flag_reg;

	////////////////////////////////////////////////////////////////////////
	// Written flags: a word never written reads back as a fault
	always_comb begin
		written_next = written_reg;
		if (wr_en) begin
			written_next[wr_idx] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			written_reg <= `MMRW_WORDS_RST;
		end else begin
			written_reg <= written_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array write and registered read
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			word_mem[wr_idx] <= wr_data;
		end
		if (rd_en) begin
			q_reg <= word_mem[rd_idx];
			flag_reg <= written_reg[rd_idx];
		end
	end

	assign rd_q = q_reg;
	assign rd_written = flag_reg;

endmodule

// >>> hdl/mmrw_pkg.sv
/*
 * Types of the read/write endpoint: status codes, states and carriers.
 * Assumes mmrw_consts.svh is on the include path.
 */
`include "mmrw_consts.svh"

package mmrw_pkg;

	// Read status codes; 2'h1 is reserved and never driven
	typedef enum logic [`MMRW_STAT_W-1:0] {
		MMRW_SUCCESS_CODE = 2'b00,
		MMRW_RESERVED_CODE = 2'b01,
		MMRW_ENDPOINT_FAULT = 2'b10,
		MMRW_UNMAPPED_FAULT = 2'b11
	} mmrw_status_e;

	// Transfer sequencer states
	typedef enum logic {
		MMRW_IDLE = 1'b0,
		MMRW_BURST = 1'b1
	} mmrw_state_e;

	// Request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic debug;
		logic [`MMRW_ADDR_W-1:0] addr;
		logic [`MMRW_BURST_W-1:0] burst;
		logic [`MMRW_DATA_W-1:0] wdata;
	} mmrw_req_s;

	// Returned read beat
	typedef struct packed {
		logic valid;
		mmrw_status_e status;
		logic [`MMRW_DATA_W-1:0] rdata;
	} mmrw_rsp_s;

endpackage

// >>> hdl/mmrw_resp.sv
/*
 * Return stage: one registered read beat with its status code.
 * Assumes its inputs arrive one cycle after the beat was issued.
 */
`timescale 1ns/100ps
`include "mmrw_consts.svh"

module mmrw_resp (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Beat from the memory stage
	input wire logic beat_valid,
	input wire logic beat_mapped,
	input wire logic beat_written,
	input wire logic [`MMRW_DATA_W-1:0] beat_data,
	// Beat toward the master
	output mmrw_pkg::mmrw_rsp_s rsp
);

	mmrw_pkg::mmrw_rsp_s rsp_reg;
	mmrw_pkg::mmrw_rsp_s rsp_next;

	// Status of one beat; unmapped outranks an unwritten word
	function automatic mmrw_pkg::mmrw_status_e beat_status(
		input logic mapped,
		input logic written
	);
		if (!mapped) begin
			beat_status = mmrw_pkg::MMRW_UNMAPPED_FAULT;
		end else if (!written) begin
			beat_status = mmrw_pkg::MMRW_ENDPOINT_FAULT;
		end else begin
			beat_status = mmrw_pkg::MMRW_SUCCESS_CODE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next beat: status always travels with its word
	always_comb begin
		rsp_next.valid = beat_valid;
		rsp_next.status = mmrw_pkg::MMRW_SUCCESS_CODE;
		rsp_next.rdata = `MMRW_FAULT_DATA;
		if (beat_valid) begin
			rsp_next.status = beat_status(beat_mapped, beat_written);
			// Faulted beats carry a fixed word the master discards
			if (beat_mapped && beat_written) begin
				rsp_next.rdata = beat_data;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rsp_reg.valid <= 1'b0;
			rsp_reg.status <= mmrw_pkg::MMRW_SUCCESS_CODE;
			rsp_reg.rdata <= `MMRW_DATA_RST;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign rsp = rsp_reg;

endmodule

// >>> hdl/mmrw_slave.sv
/*
 * Memory-mapped read/write endpoint with per-beat read status,
 * read bursts and a debug override for read-only memory.
 * Assumes a master on the same clock that holds its request while
 * waitrequest is high and that treats a faulted read word as void.
 */
// Notes on behaviour
// - Debug override lets writes reach read-only memory
// - Read strobe marks a read; read word present
// - Slave returns a read word per read
// - Two-bit status travels with each read word
// - Status codes fixed; reserved code never produced
// - Burst of n returns exactly n statuses
// - Status exists only on this read-capable port
// - Faulted read word is arbitrary; master discards
// - Every accepted read receives a status
// - Write strobe marks a write with data
// - Read and write words share one width
`timescale 1ns/100ps
`include "mmrw_consts.svh"

module mmrw_slave (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Configuration: memory is read-only unless debug override
	input wire logic rom_cfg,
	// Request from the master
	input mmrw_pkg::mmrw_req_s req,
	// Answer toward the master
	output logic waitrequest,
	output mmrw_pkg::mmrw_rsp_s rsp
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Sequencer state
	mmrw_pkg::mmrw_state_e state_reg;
	mmrw_pkg::mmrw_state_e state_next;
	logic wait_reg;
	logic wait_next;
	// Address of the next burst beat and beats still to issue
	logic [`MMRW_ADDR_W-1:0] addr_reg;
	logic [`MMRW_ADDR_W-1:0] addr_next;
	logic [`MMRW_BURST_W-1:0] left_reg;
	logic [`MMRW_BURST_W-1:0] left_next;
	// Memory stage flags, aligned with the memory read data
	logic issue_d_reg;
	logic issue_d_next;
	logic mapped_d_reg;
	logic mapped_d_next;
	// Decoded strobes and per-cycle beat
	logic read_on;
	logic write_on;
	logic accept_rd;
	logic accept_wr;
	logic issue;
	logic [`MMRW_ADDR_W-1:0] beat_addr;
	logic [`MMRW_BURST_W-1:0] beats;
	logic mem_we;
	logic [`MMRW_DATA_W-1:0] mem_q;
	logic mem_written;

	// Strobe level to meaning, for either polarity variant
	function automatic logic strobe_on(input logic raw);
		strobe_on = raw ^ `MMRW_STROBE_LOW;
	endfunction

	// Word address falls inside the memory
	function automatic logic is_mapped(
		input logic [`MMRW_ADDR_W-1:0] a
	);
		is_mapped = !a[`MMRW_MAP_BIT];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Request decode; only taken while waitrequest is low, which relies on
	// the master holding its request stable until then
	always_comb begin
		read_on = strobe_on(req.read);
		write_on = strobe_on(req.write);
		accept_rd = (state_reg == mmrw_pkg::MMRW_IDLE) && !wait_reg &&
			read_on;
		// A read wins if a faulty master raises both strobes
		accept_wr = (state_reg == mmrw_pkg::MMRW_IDLE) && !wait_reg &&
			write_on && !read_on;
		// Zero length is taken as a single beat
		if (req.burst == `MMRW_NO_BEAT) begin
			beats = `MMRW_ONE_BEAT;
		end else begin
			beats = req.burst;
		end
		// Read-only memory takes writes only under debug override
		mem_we = accept_wr && is_mapped(req.addr) &&
			(!rom_cfg || req.debug);
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: issues one beat per cycle; waitrequest covers the burst
	always_comb begin
		state_next = state_reg;
		wait_next = 1'b0;
		addr_next = addr_reg;
		left_next = left_reg;
		issue = 1'b0;
		beat_addr = req.addr;
		case (state_reg)
			mmrw_pkg::MMRW_IDLE: begin
				if (accept_rd) begin
					issue = 1'b1;
					beat_addr = req.addr;
					if (beats != `MMRW_ONE_BEAT) begin
						state_next = mmrw_pkg::MMRW_BURST;
						wait_next = 1'b1;
						addr_next = req.addr + `MMRW_ONE_ADDR;
						left_next = beats - `MMRW_ONE_BEAT;
					end
				end
			end
			mmrw_pkg::MMRW_BURST: begin
				// One beat, hence one status, per cycle of the burst
				issue = 1'b1;
				beat_addr = addr_reg;
				addr_next = addr_reg + `MMRW_ONE_ADDR;
				left_next = left_reg - `MMRW_ONE_BEAT;
				if (left_reg == `MMRW_ONE_BEAT) begin
					state_next = mmrw_pkg::MMRW_IDLE;
				end else begin
					wait_next = 1'b1;
				end
			end
			default: begin
				// Unreachable code point; recover to idle
				state_next = mmrw_pkg::MMRW_IDLE;
				wait_next = 1'b1;
			end
		endcase
		// Memory stage flags follow the issued beat
		issue_d_next = issue;
		mapped_d_next = is_mapped(beat_addr);
	end

	// Waitrequest resets high so nothing is taken during reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_reg <= mmrw_pkg::MMRW_IDLE;
			wait_reg <= `MMRW_WAIT_RST;
			addr_reg <= `MMRW_ADDR_RST;
			left_reg <= `MMRW_NO_BEAT;
			issue_d_reg <= 1'b0;
			mapped_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			addr_reg <= addr_next;
			left_reg <= left_next;
			issue_d_reg <= issue_d_next;
			mapped_d_reg <= mapped_d_next;
		end
	end

	assign waitrequest = wait_reg;

	////////////////////////////////////////////////////////////////////////
	// Storage and return stage; one shared data width both ways
	mmrw_mem u_mem (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.rd_en(issue && is_mapped(beat_addr)),
		.rd_idx(beat_addr[`MMRW_IDX_W-1:0]),
		.rd_q(mem_q),
		.rd_written(mem_written),
		.wr_en(mem_we),
		.wr_idx(req.addr[`MMRW_IDX_W-1:0]),
		.wr_data(req.wdata)
	);

	// Status output exists only beside the read word
	mmrw_resp u_resp (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.beat_valid(issue_d_reg),
		.beat_mapped(mapped_d_reg),
		.beat_written(mem_written),
		.beat_data(mem_q),
		.rsp(rsp)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// Beats accepted but not yet returned
	logic [5:0] pend_reg;
	// Last word written into the memory
	logic [`MMRW_ADDR_W-1:0] last_addr_reg;
	logic [`MMRW_DATA_W-1:0] last_data_reg;
	logic last_ok_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pend_reg <= 6'h00;
			last_addr_reg <= `MMRW_ADDR_RST;
			last_data_reg <= `MMRW_DATA_RST;
			last_ok_reg <= 1'b0;
		end else begin
			pend_reg <= pend_reg + (accept_rd ? {2'h0, beats} : 6'h00) -
				{5'h00, rsp.valid};
			if (mem_we) begin
				last_addr_reg <= req.addr;
				last_data_reg <= req.wdata;
				last_ok_reg <= 1'b1;
			end
		end
	end

	// The reserved code never appears
	property p_no_reserved;
		rsp.valid |-> rsp.status != mmrw_pkg::MMRW_RESERVED_CODE;
	endproperty
	a_no_reserved: assert property (p_no_reserved)
		else $error("reserved status driven");

	// Each issued beat returns two cycles later
	property p_read_answer;
		issue |-> ##2 rsp.valid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("issued read beat got no answer");

	// No answer without a beat issued two cycles before
	property p_no_stray;
		rsp.valid |-> $past(issue, 2);
	endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("read answer without a request");

	// Once quiet, every accepted beat has been answered
	property p_beats_match;
		!$past(issue) && !$past(issue, 2) && !issue_d_reg |->
			pend_reg == 6'h00;
	endproperty
	a_beats_match: assert property (p_beats_match)
		else $error("burst answer count differs from length");

	// Unmapped beat reports an unmapped fault
	property p_unmapped;
		issue && !is_mapped(beat_addr) |->
			##2 rsp.status == mmrw_pkg::MMRW_UNMAPPED_FAULT;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not reported");

	// Reading back the last written word succeeds with its data
	property p_read_back;
		issue && last_ok_reg && beat_addr == last_addr_reg |->
			##2 rsp.status == mmrw_pkg::MMRW_SUCCESS_CODE &&
			rsp.rdata == $past(last_data_reg, 2);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("read back data or status wrong");

	// Debug override stores into read-only memory
	property p_debug_write;
		accept_wr && rom_cfg && req.debug && is_mapped(req.addr) |=>
			last_addr_reg == $past(req.addr) &&
			last_data_reg == $past(req.wdata);
	endproperty
	a_debug_write: assert property (p_debug_write)
		else $error("debug write to read-only memory lost");

	// Without override, read-only memory stays untouched
	property p_rom_block;
		accept_wr && rom_cfg && !req.debug |=>
			$stable(last_addr_reg) && $stable(last_data_reg);
	endproperty
	a_rom_block: assert property (p_rom_block)
		else $error("read-only memory written without override");

	// Faulted beats carry the fixed word
	property p_fault_data;
		rsp.valid && rsp.status != mmrw_pkg::MMRW_SUCCESS_CODE |->
			rsp.rdata == `MMRW_FAULT_DATA;
	endproperty
	a_fault_data: assert property (p_fault_data)
		else $error("faulted beat carries live data");

	// Status rests at success outside answer beats
	property p_status_idle;
		!rsp.valid |-> rsp.status == mmrw_pkg::MMRW_SUCCESS_CODE;
	endproperty
	a_status_idle: assert property (p_status_idle)
		else $error("status driven without read word");

	// Requests are held off while a burst runs
	property p_burst_wait;
		state_reg == mmrw_pkg::MMRW_BURST |-> waitrequest;
	endproperty
	a_burst_wait: assert property (p_burst_wait)
		else $error("waitrequest low during burst");

	// Main scenarios
	c_burst: cover property (accept_rd && beats == 4'h3 ##4 rsp.valid);
	c_debug: cover property (accept_wr && rom_cfg && req.debug);
	c_unmapped: cover property (rsp.valid &&
		rsp.status == mmrw_pkg::MMRW_UNMAPPED_FAULT);
	c_endpoint: cover property (rsp.valid &&
		rsp.status == mmrw_pkg::MMRW_ENDPOINT_FAULT);

endmodule

// >>> sim/mmrw_master.sv
/*
 * Master model for the read/write endpoint: presents one request at a
 * time and logs every returned read beat.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/100ps
`include "mmrw_consts.svh"

module mmrw_master (
	// Clock
	input wire logic sys_clk,
	// Answer from the slave
	input wire logic waitrequest,
	input mmrw_pkg::mmrw_rsp_s rsp,
	// Request toward the slave
	output mmrw_pkg::mmrw_req_s req
);
	logic [1:0] stat_q[$]; // Logged status codes
	logic [`MMRW_DATA_W-1:0] data_q[$]; // Logged read words
	// Single master with no hold-grant line: it never locks a sequence,
	// so grant keeping and lock priority never arise on this bench
	localparam bit hold_grant_used = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		req.read = `MMRW_STROBE_LOW;
		req.write = `MMRW_STROBE_LOW;
		req.debug = 1'b0;
		req.addr = '0;
		req.burst = '0;
		req.wdata = '0;
	end

	// Log beats mid-cycle, where the registered outputs have settled
	always @(negedge sys_clk) begin
		if (rsp.valid === 1'b1) begin
			stat_q.push_back(rsp.status);
			data_q.push_back(rsp.rdata);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drive one request and hold it until an edge takes it
	task automatic issue(input logic rd, input logic wr, input logic dbg,
		input logic [`MMRW_ADDR_W-1:0] adr, input logic [3:0] len,
		input logic [`MMRW_DATA_W-1:0] wd, output bit ok);
		int n;
		ok = 1'b0;
		#1;
		req.read = rd ^ `MMRW_STROBE_LOW;
		req.write = wr ^ `MMRW_STROBE_LOW;
		req.debug = dbg;
		req.addr = adr;
		// A locking master would be limited to single beats
		req.burst = hold_grant_used ? `MMRW_ONE_BEAT : len;
		req.wdata = wd;
		// Bounded hold; the value seen now is what the next edge samples
		for (n = 0; n < 20 && !ok; n++) begin
			if (waitrequest === 1'b0) begin
				ok = 1'b1;
			end
			@(posedge sys_clk);
			if (!ok) begin
				#1;
			end
		end
	endtask

	// Release the bus; stale lines turn over so they are never reused
	task automatic idle();
		#1;
		req.read = `MMRW_STROBE_LOW;
		req.write = `MMRW_STROBE_LOW;
		req.debug = 1'b0;
		req.addr = ~req.addr;
		req.wdata = ~req.wdata;
		@(posedge sys_clk);
	endtask
endmodule

// >>> sim/mmrw_slave_bench.sv
/*
 * Self-checking bench of the read/write endpoint: reset, faults, bursts,
 * unmapped space and the read-only override.
 * Assumes the endpoint answers reads two cycles after taking them.
 */
`timescale 1ns/100ps
`include "mmrw_consts.svh"

module mmrw_slave_bench;
	logic sys_clk; // Bench clock
	logic rst_b; // Synchronous reset, active low
	logic rom_cfg; // Memory read-only when high
	logic waitrequest; // Slave stall
	mmrw_pkg::mmrw_req_s req; // Master request
	mmrw_pkg::mmrw_rsp_s rsp; // Returned beat
	int errors; // Mismatches
	int comparisons; // Compares made

	mmrw_slave dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .rom_cfg(rom_cfg),
		.req(req), .waitrequest(waitrequest), .rsp(rsp));
	mmrw_master mst_u (.sys_clk(sys_clk), .waitrequest(waitrequest),
		.rsp(rsp), .req(req));

	////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One request; a stall beyond the bound ends the run
	task automatic send(input logic rd, input logic wr, input logic dbg,
		input logic [8:0] adr, input logic [3:0] len, input logic [31:0] wd);
		bit ok;
		mst_u.issue(rd, wr, dbg, adr, len, wd, ok);
		if (!ok) begin
			errors++;
			wrap_up();
		end
	endtask

	// Wait, bounded, for the next beat and judge it
	task automatic beat(input logic [1:0] st, input logic [31:0] d);
		int n;
		for (n = 0; n < 10 && mst_u.stat_q.size() == 0; n++) begin
			@(posedge sys_clk);
		end
		if (mst_u.stat_q.size() == 0) begin
			errors++;
			wrap_up();
		end
		check("status", mst_u.stat_q.pop_front(), st);
		check("rdata", mst_u.data_q.pop_front(), d);
	endtask

	// No beat beyond those already judged
	task automatic quiet();
		repeat (4) @(posedge sys_clk);
		check("extra_beats", mst_u.stat_q.size(), 0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Stall during reset, then open
	task automatic t_reset();
		repeat (19) @(posedge sys_clk);
		#1;
		check("wait_in_reset", waitrequest, 1'b1);
		check("valid_in_reset", rsp.valid, 1'b0);
		@(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		@(posedge sys_clk);
		// Stall lifts after the first edge out of reset
		@(negedge sys_clk);
		check("wait_after_reset", waitrequest, 1'b0);
		@(posedge sys_clk);
	endtask

	// Unwritten word faults; write then read back to back
	task automatic t_single();
		send(1'b1, 1'b0, 1'b0, 9'h005, 4'h1, 32'h0);
		mst_u.idle();
		beat(2'b10, 32'h0);
		send(1'b0, 1'b1, 1'b0, 9'h010, 4'h1, 32'hA5C3_0F1E);
		send(1'b1, 1'b0, 1'b0, 9'h010, 4'h1, 32'h0);
		mst_u.idle();
		beat(2'b00, 32'hA5C3_0F1E);
		quiet();
	endtask

	// Bursts with mixed status, one crossing into unmapped space
	task automatic t_burst();
		send(1'b0, 1'b1, 1'b0, 9'h012, 4'h1, 32'h1234_5678);
		send(1'b1, 1'b0, 1'b0, 9'h010, 4'h3, 32'h0);
		send(1'b1, 1'b0, 1'b0, 9'h0FF, 4'h2, 32'h0);
		mst_u.idle();
		beat(2'b00, 32'hA5C3_0F1E);
		beat(2'b10, 32'h0);
		beat(2'b00, 32'h1234_5678);
		beat(2'b10, 32'h0);
		beat(2'b11, 32'h0);
		quiet();
	endtask

	// Unmapped write dropped; zero length reads one beat
	task automatic t_unmapped();
		send(1'b0, 1'b1, 1'b0, 9'h105, 4'h1, 32'hFFFF_0000);
		send(1'b1, 1'b0, 1'b0, 9'h105, 4'h0, 32'h0);
		// Both strobes: taken as a read, the write is dropped
		send(1'b1, 1'b1, 1'b0, 9'h030, 4'h1, 32'h5A5A_5A5A);
		send(1'b1, 1'b0, 1'b0, 9'h030, 4'h1, 32'h0);
		mst_u.idle();
		beat(2'b11, 32'h0);
		beat(2'b10, 32'h0);
		beat(2'b10, 32'h0);
		quiet();
	endtask

	// Read-only memory takes writes only under debug override
	task automatic t_rom();
		#1;
		rom_cfg = 1'b1;
		@(posedge sys_clk);
		send(1'b0, 1'b1, 1'b0, 9'h020, 4'h1, 32'h0BAD_0BAD);
		send(1'b1, 1'b0, 1'b0, 9'h020, 4'h1, 32'h0);
		send(1'b0, 1'b1, 1'b1, 9'h021, 4'h1, 32'hC0DE_0001);
		send(1'b1, 1'b0, 1'b0, 9'h021, 4'h1, 32'h0);
		mst_u.idle();
		beat(2'b10, 32'h0);
		beat(2'b00, 32'hC0DE_0001);
		quiet();
		#1;
		rom_cfg = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		errors = 0;
		comparisons = 0;
		rst_b = 1'b0;
		rom_cfg = 1'b0;
		t_reset();
		t_single();
		t_burst();
		t_unmapped();
		t_rom();
		wrap_up();
	end
endmodule
